// ==== hdl/adcc_map.vh ====
// register map, field positions, codes and timing of the converter control block
`ifndef ADCC_MAP_VH
`define ADCC_MAP_VH

// register addresses on the plain register port
`define ADCC_CTRL_ADDR      4'h0
`define ADCC_STAT_ADDR      4'h4

// control register reset value: divide by 2, 8-clock acquisition, all else clear
`define ADCC_CTRL_RESET     16'h0600

// control register field positions
`define ADCC_DIV_MSB        12
`define ADCC_DIV_LSB        10
`define ADCC_ACQ_MSB        9
`define ADCC_ACQ_LSB        8
`define ADCC_START_EN_BIT   7
`define ADCC_BUSY_EN_BIT    6
`define ADCC_POWER_BIT      5
`define ADCC_MODE_MSB       4
`define ADCC_MODE_LSB       3
`define ADCC_TYPE_MSB       2
`define ADCC_TYPE_LSB       0

// status register bit positions
`define ADCC_STAT_BUSY_BIT  0
`define ADCC_STAT_SETTLED_BIT 1
`define ADCC_STAT_CONT_BIT  2
`define ADCC_STAT_SWREQ_BIT 3

// conversion type codes
`define ADCC_TYPE_EXT       3'h0
`define ADCC_TYPE_TMR1      3'h1
`define ADCC_TYPE_TMR0      3'h2
`define ADCC_TYPE_SINGLE    3'h3
`define ADCC_TYPE_CONT      3'h4
`define ADCC_TYPE_PLA       3'h5

// input mode codes
`define ADCC_MODE_SINGLE    2'h0
`define ADCC_MODE_DIFF      2'h1
`define ADCC_MODE_PSEUDO    2'h2
`define ADCC_MODE_RSVD      2'h3

// converter clock divider codes
`define ADCC_DIV_MIN        3'h1
`define ADCC_DIV_MAX        3'h5

// timing
`define ADCC_CLK_PERIOD_NS  20
`define ADCC_SETTLE_NS      5000
`define ADCC_SETTLE_CYCLES  ((`ADCC_SETTLE_NS + `ADCC_CLK_PERIOD_NS - 1) / `ADCC_CLK_PERIOD_NS)

`endif

// ==== hdl/adcc_clk_div.v ====
// converter clock divider: a tick every 2**code system clocks
`timescale 1ns/100ps
`include "adcc_map.vh"

module adcc_clk_div
(
    input  wire       sys_clk,
    input  wire       srst,
    input  wire [2:0] div_code,
    output reg        tick_reg,
    output reg        conv_clk_reg
);

    reg  [4:0] cnt_reg;
    reg  [2:0] code_eff;
    wire [4:0] last_cnt;

    // reserved divider codes are clamped to the nearest legal ratio
    always @*
    begin
        if (div_code < `ADCC_DIV_MIN)
            code_eff = `ADCC_DIV_MIN;
        else if (div_code > `ADCC_DIV_MAX)
            code_eff = `ADCC_DIV_MAX;
        else
            code_eff = div_code;
    end

    assign last_cnt = (5'h01 << code_eff) - 5'h01; // [R13]

    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            cnt_reg      <= 5'h00;
            tick_reg     <= 1'b0;
            conv_clk_reg <= 1'b0;
        end
        else
        begin
            // a divider change mid-count restarts cleanly at the next wrap
            if (cnt_reg >= last_cnt)
                cnt_reg <= 5'h00;
            else
                cnt_reg <= cnt_reg + 5'h01;
            tick_reg     <= (cnt_reg >= last_cnt); // [R13]
            conv_clk_reg <= (cnt_reg >= (last_cnt >> 1)) && (cnt_reg < last_cnt);
        end
    end

endmodule // adcc_clk_div

// ==== hdl/adcc_control.v ====
// converter control: control register, trigger selection and conversion sequencer
//
// How it works
// R1: bits 9:8 pick an acquisition window of 2, 4, 8 or 16 converter clocks, 8 after reset.
// R2: a configured trigger starts a conversion only while the start enable bit is set.
// R3: continuous conversion keeps running even after the start enable bit is cleared.
// R4: the busy enable bit decides whether the busy indication is driven onto its pin.
// R5: the power bit puts the converter in normal mode when set and power-down when clear.
// R6: software waits at least 5 us after power-up before asking for a conversion.
// R7: the input mode field picks single-ended, differential or pseudo differential; 11 is unused.
// R8: type 000 starts conversions from the external trigger pin.
// R9: type 011 runs one software conversion and the type returns to 000 when it ends.
// R10: software clears the start enable after a single conversion so the pin cannot retrigger.
// R11: type 100 runs back-to-back conversions until the type is changed.
// R12: type 101 starts conversions from the programmable logic trigger.
// R13: the divider field sets the converter clock to a ratio of 2, 4, 8, 16 or 32.
// R14: types 001 and 010 start conversions from general timer one and timer zero.
// R15: the busy indication runs from the start of acquisition to the end of conversion.
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "adcc_map.vh"

module adcc_control
#(
    parameter CONV_TICKS = 13,
    parameter CNT_W      = 6
)
(
    input  wire        sys_clk,
    input  wire        srst,
    input  wire [3:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    input  wire        external_trigger_pin,
    input  wire        general_timer_one,
    input  wire        general_timer_zero,
    input  wire        programmable_logic_trigger,
    output wire        converter_clock,
    output reg         conv_power_en,
    output reg  [1:0]  conv_input_mode,
    output reg         conv_sample_en,
    output reg         conv_start_pulse,
    output reg         conv_done_pulse,
    output reg         conversion_active_pin,
    output reg         conversion_active_pin_oe_n,
    output reg         power_settled
);

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ACQ  = 2'h1;
    localparam [1:0] ST_CONV = 2'h2;
    localparam [1:0] ST_DONE = 2'h3;

    // integer forms are cut to the counter widths on purpose
    localparam integer     SETTLE_FULL    = `ADCC_SETTLE_CYCLES;
    localparam integer     CONV_LAST_FULL = CONV_TICKS - 1;
    localparam [8:0]       SETTLE_CYC     = SETTLE_FULL[8:0];
    localparam [CNT_W-1:0] CONV_LAST      = CONV_LAST_FULL[CNT_W-1:0];

    reg  [15:0]      ctrl_reg;
    reg  [15:0]      ctrl_next;
    reg  [1:0]       state_reg;
    reg  [1:0]       state_next;
    reg  [CNT_W-1:0] tick_cnt_reg;
    reg  [CNT_W-1:0] tick_cnt_next;
    reg              sw_req_reg;
    reg              sw_req_next;
    reg              single_run_reg;
    reg              single_run_next;
    reg              cont_run_reg;
    reg              cont_run_next;
    reg  [8:0]       settle_cnt_reg;
    reg              ext_prev_reg;
    reg              tmr1_prev_reg;
    reg              tmr0_prev_reg;
    reg              pla_prev_reg;
    reg              sel_edge;
    reg  [CNT_W-1:0] acq_last;
    reg              launch;
    reg              launch_sw;

    wire             tick;
    wire [2:0]       div_code;
    wire [1:0]       acq_code;
    wire             start_en;
    wire             busy_en;
    wire             power_on;
    wire [2:0]       conv_type;
    wire             wr_ctrl;
    wire             active;

    assign div_code  = ctrl_reg[`ADCC_DIV_MSB:`ADCC_DIV_LSB];
    assign acq_code  = ctrl_reg[`ADCC_ACQ_MSB:`ADCC_ACQ_LSB];
    assign start_en  = ctrl_reg[`ADCC_START_EN_BIT];
    assign busy_en   = ctrl_reg[`ADCC_BUSY_EN_BIT];
    assign power_on  = ctrl_reg[`ADCC_POWER_BIT];
    assign conv_type = ctrl_reg[`ADCC_TYPE_MSB:`ADCC_TYPE_LSB];
    assign wr_ctrl   = reg_wr && (reg_addr == `ADCC_CTRL_ADDR);
    assign active    = (state_reg == ST_ACQ) || (state_reg == ST_CONV);

    adcc_clk_div u_clk_div
    (
        .sys_clk      (sys_clk),
        .srst         (srst),
        .div_code     (div_code),
        .tick_reg     (tick),
        .conv_clk_reg (converter_clock)
    );

    // acquisition window length in converter clocks, less one
    always @*
    begin
        case (acq_code)
            2'h0:    acq_last = 6'h01; // [R1]
            2'h1:    acq_last = 6'h03; // [R1]
            2'h2:    acq_last = 6'h07; // [R1]
            default: acq_last = 6'h0F; // [R1]
        endcase
    end

    // trigger sources are taken on their rising edge so a held level gives one start
    always @*
    begin
        case (conv_type)
            `ADCC_TYPE_EXT:  sel_edge = external_trigger_pin && !ext_prev_reg; // [R8]
            `ADCC_TYPE_TMR1: sel_edge = general_timer_one && !tmr1_prev_reg; // [R14]
            `ADCC_TYPE_TMR0: sel_edge = general_timer_zero && !tmr0_prev_reg; // [R14]
            `ADCC_TYPE_PLA:  sel_edge = programmable_logic_trigger && !pla_prev_reg; // [R12]
            default:         sel_edge = 1'b0;
        endcase
    end

    // start decision
    always @*
    begin
        launch    = 1'b0;
        launch_sw = 1'b0;
        if ((state_reg == ST_IDLE) && power_on)
        begin
            if (conv_type == `ADCC_TYPE_CONT)
            begin
                // once running, the enable bit no longer gates restarts
                launch = start_en || cont_run_reg; // [R2] [R3] [R11]
            end
            else if (conv_type == `ADCC_TYPE_SINGLE)
            begin
                launch    = start_en && sw_req_reg; // [R2] [R9]
                launch_sw = start_en && sw_req_reg;
            end
            else
            begin
                launch = start_en && sel_edge; // [R2]
            end
        end
    end

    // sequencer
    always @*
    begin
        state_next      = state_reg;
        tick_cnt_next   = tick_cnt_reg;
        single_run_next = single_run_reg;
        cont_run_next   = cont_run_reg;
        case (state_reg)
            ST_IDLE:
            begin
                tick_cnt_next = {CNT_W{1'b0}};
                if (launch)
                begin
                    state_next      = ST_ACQ; // [R15]
                    single_run_next = launch_sw;
                    cont_run_next   = (conv_type == `ADCC_TYPE_CONT);
                end
            end
            ST_ACQ:
            begin
                if (tick)
                begin
                    if (tick_cnt_reg >= acq_last)
                    begin
                        state_next    = ST_CONV; // [R1]
                        tick_cnt_next = {CNT_W{1'b0}};
                    end
                    else
                    begin
                        tick_cnt_next = tick_cnt_reg + 1'b1;
                    end
                end
            end
            ST_CONV:
            begin
                if (tick)
                begin
                    if (tick_cnt_reg >= CONV_LAST)
                    begin
                        state_next    = ST_DONE;
                        tick_cnt_next = {CNT_W{1'b0}};
                    end
                    else
                    begin
                        tick_cnt_next = tick_cnt_reg + 1'b1;
                    end
                end
            end
            default:
            begin
                state_next      = ST_IDLE;
                single_run_next = 1'b0;
            end
        endcase
        // powering down aborts a conversion in flight
        if (!power_on)
        begin
            state_next      = ST_IDLE; // [R5]
            tick_cnt_next   = {CNT_W{1'b0}};
            single_run_next = 1'b0;
        end
        // leaving continuous mode or powering down stops the free run
        if ((conv_type != `ADCC_TYPE_CONT) || !power_on)
            cont_run_next = 1'b0; // [R11]
    end

    // control register write and hardware rewrite of the type field
    always @*
    begin
        ctrl_next = ctrl_reg;
        if ((state_reg == ST_DONE) && single_run_reg)
            ctrl_next[`ADCC_TYPE_MSB:`ADCC_TYPE_LSB] = `ADCC_TYPE_EXT; // [R9]
        // a software write in the same cycle is the newer command and wins
        if (wr_ctrl)
        begin
            ctrl_next = reg_wdata;
            ctrl_next[15:13] = 3'h0;
            // the reserved input mode is refused; the previous mode stays
            if (reg_wdata[`ADCC_MODE_MSB:`ADCC_MODE_LSB] == `ADCC_MODE_RSVD)
                ctrl_next[`ADCC_MODE_MSB:`ADCC_MODE_LSB] =
                    ctrl_reg[`ADCC_MODE_MSB:`ADCC_MODE_LSB]; // [R7]
        end
    end

    // pending software single request: a new write of type 011 arms it
    always @*
    begin
        sw_req_next = sw_req_reg;
        if (wr_ctrl && (reg_wdata[`ADCC_TYPE_MSB:`ADCC_TYPE_LSB] == `ADCC_TYPE_SINGLE))
            sw_req_next = 1'b1; // [R9]
        else if (launch_sw || (conv_type != `ADCC_TYPE_SINGLE))
            sw_req_next = 1'b0;
    end

    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            ctrl_reg       <= `ADCC_CTRL_RESET; // [R1] [R13]
            state_reg      <= ST_IDLE;
            tick_cnt_reg   <= {CNT_W{1'b0}};
            sw_req_reg     <= 1'b0;
            single_run_reg <= 1'b0;
            cont_run_reg   <= 1'b0;
            ext_prev_reg   <= 1'b0;
            tmr1_prev_reg  <= 1'b0;
            tmr0_prev_reg  <= 1'b0;
            pla_prev_reg   <= 1'b0;
        end
        else
        begin
            ctrl_reg       <= ctrl_next;
            state_reg      <= state_next;
            tick_cnt_reg   <= tick_cnt_next;
            sw_req_reg     <= sw_req_next;
            single_run_reg <= single_run_next;
            cont_run_reg   <= cont_run_next;
            ext_prev_reg   <= external_trigger_pin;
            tmr1_prev_reg  <= general_timer_one;
            tmr0_prev_reg  <= general_timer_zero;
            pla_prev_reg   <= programmable_logic_trigger;
        end
    end

    // settling counter only reports; the wait itself is left to software
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            settle_cnt_reg <= 9'h000;
            power_settled  <= 1'b0;
        end
        else if (!power_on)
        begin
            settle_cnt_reg <= 9'h000;
            power_settled  <= 1'b0;
        end
        else
        begin
            if (settle_cnt_reg < SETTLE_CYC)
                settle_cnt_reg <= settle_cnt_reg + 9'h001;
            power_settled <= (settle_cnt_reg >= SETTLE_CYC); // [R6]
        end
    end

    // outputs toward the analog core and the busy pin
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            conv_power_en              <= 1'b0;
            conv_input_mode            <= `ADCC_MODE_SINGLE;
            conv_sample_en             <= 1'b0;
            conv_start_pulse           <= 1'b0;
            conv_done_pulse            <= 1'b0;
            conversion_active_pin      <= 1'b0;
            conversion_active_pin_oe_n <= 1'b1;
        end
        else
        begin
            conv_power_en    <= ctrl_next[`ADCC_POWER_BIT]; // [R5]
            conv_input_mode  <= ctrl_next[`ADCC_MODE_MSB:`ADCC_MODE_LSB]; // [R7]
            conv_sample_en   <= (state_next == ST_ACQ);
            conv_start_pulse <= (state_reg == ST_ACQ) && (state_next == ST_CONV);
            conv_done_pulse  <= (state_next == ST_DONE);
            // pin low when disabled so an undriven board net is never read as busy
            conversion_active_pin <= ctrl_next[`ADCC_BUSY_EN_BIT] &&
                ((state_next == ST_ACQ) || (state_next == ST_CONV)); // [R4] [R15]
            conversion_active_pin_oe_n <= !ctrl_next[`ADCC_BUSY_EN_BIT]; // [R4]
        end
    end

    // register read: data in the cycle after the strobe only, unmapped reads zero
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            reg_rdata <= 16'h0000;
        end
        else if (reg_rd)
        begin
            if (reg_addr == `ADCC_CTRL_ADDR)
            begin
                reg_rdata <= ctrl_reg;
            end
            else if (reg_addr == `ADCC_STAT_ADDR)
            begin
                reg_rdata <= 16'h0000;
                reg_rdata[`ADCC_STAT_BUSY_BIT]    <= active;
                reg_rdata[`ADCC_STAT_SETTLED_BIT] <= power_settled;
                reg_rdata[`ADCC_STAT_CONT_BIT]    <= cont_run_reg;
                reg_rdata[`ADCC_STAT_SWREQ_BIT]   <= sw_req_reg;
            end
            else
            begin
                reg_rdata <= 16'h0000;
            end
        end
        else
        begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule // adcc_control

// ==== test/adcc_control_monitor.sv ====
// port checker for the converter control block
`timescale 1ns/100ps
`include "adcc_map.vh"

module adcc_monitor
#(
    parameter CONV_TICKS = 13,
    parameter CNT_W      = 6
)
(
    input wire        sys_clk,
    input wire        srst,
    input wire [3:0]  reg_addr,
    input wire [15:0] reg_wdata,
    input wire        reg_wr,
    input wire        conv_power_en,
    input wire [1:0]  conv_input_mode,
    input wire        conv_sample_en,
    input wire        conv_start_pulse,
    input wire        conv_done_pulse,
    input wire        conversion_active_pin,
    input wire        conversion_active_pin_oe_n,
    input wire        power_settled
);
    // shadow of the fields hardware never rewrites; age lets outputs settle
    reg [1:0] age_reg;
    reg       busy_en_reg;
    reg       power_reg;
    reg [1:0] mode_reg;
    reg [8:0] on_reg;
    wire      ctrl_wr = reg_wr && (reg_addr == `ADCC_CTRL_ADDR);

    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            age_reg <= 2'h3;
            busy_en_reg <= 1'b0;
            power_reg <= 1'b0;
            mode_reg <= 2'h0;
        end
        else if (ctrl_wr)
        begin
            age_reg <= 2'h0;
            busy_en_reg <= reg_wdata[`ADCC_BUSY_EN_BIT];
            power_reg <= reg_wdata[`ADCC_POWER_BIT];
            if (reg_wdata[4:3] != `ADCC_MODE_RSVD)
                mode_reg <= reg_wdata[4:3];
        end
        else if (age_reg != 2'h3)
            age_reg <= age_reg + 2'h1;
    end

    // cycles the power output has been held high, saturating
    always @(posedge sys_clk)
    begin
        if (srst || !conv_power_en)
            on_reg <= 9'h000;
        else if (on_reg != 9'h1FF)
            on_reg <= on_reg + 9'h001;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    oe_follow_a:
    assert property (age_reg == 2'h3 |-> conversion_active_pin_oe_n == !busy_en_reg)
        else $error("busy pin enable does not follow control");
    pin_gate_a:
    assert property (conversion_active_pin |-> busy_en_reg || age_reg != 2'h3)
        else $error("busy pin driven while disabled");
    power_follow_a:
    assert property (age_reg == 2'h3 |-> conv_power_en == power_reg)
        else $error("power output does not follow control");
    launch_power_a:
    assert property ($rose(conv_sample_en) |-> conv_power_en)
        else $error("acquisition started while powered down");
    mode_follow_a:
    assert property (age_reg == 2'h3 |-> conv_input_mode == mode_reg)
        else $error("input mode does not follow control");
    mode_legal_a:
    assert property (conv_input_mode != `ADCC_MODE_RSVD)
        else $error("reserved input mode reached the converter");
    acq_end_a:
    assert property ($fell(conv_sample_en) && $past(conv_power_en) && conv_power_en
                     && age_reg == 2'h3 |-> ##[0:1] conv_start_pulse)
        else $error("acquisition ended without conversion start");
    conv_gap_a:
    assert property (conv_start_pulse |=> (!conv_sample_en && !conv_done_pulse) [*8])
        else $error("conversion phase cut short");
    done_idle_a:
    assert property (conv_done_pulse |=> !conversion_active_pin && !conv_sample_en)
        else $error("busy indication held past result");
    acq_busy_a:
    assert property (conv_sample_en && busy_en_reg && age_reg == 2'h3 |-> conversion_active_pin)
        else $error("busy pin low during acquisition");
    settle_count_a:
    assert property ($rose(power_settled) |-> on_reg >= 9'h0F0)
        else $error("power reported settled too early");
endmodule // adcc_monitor

bind adcc_control adcc_monitor #(.CONV_TICKS(CONV_TICKS), .CNT_W(CNT_W)) u_mon (.sys_clk,
    .srst, .reg_addr, .reg_wdata, .reg_wr, .conv_power_en, .conv_input_mode, .conv_sample_en,
    .conv_start_pulse, .conv_done_pulse, .conversion_active_pin,
    .conversion_active_pin_oe_n, .power_settled);

// ==== test/testbench.sv ====
// self-checking bench for the converter control block
`timescale 1ns/100ps
`include "adcc_map.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %s expected %h seen %h", n, e, g); end end

module testbench;
    reg         sys_clk   = 1'b0;
    reg         srst      = 1'b1;
    reg  [3:0]  reg_addr  = 4'h0;
    reg  [15:0] reg_wdata = 16'h0000;
    reg         reg_wr    = 1'b0;
    reg         reg_rd    = 1'b0;
    reg  [3:0]  trig      = 4'h0;
    wire [15:0] reg_rdata;
    wire [1:0]  mode;
    wire        conv_clk, pwr, samp, startp, donep, act, act_oe_n, settled;
    int         fail_count = 0;
    int         comparisons = 0;
    int         cycles = 0;
    int         acq_run = 0;
    int         acq_len = 0;
    int         i, n, m;
    reg         prv;
    reg  [2:0]  tt [4] = '{3'h0, 3'h1, 3'h2, 3'h5};
    // divide by 2, 2-clock acquisition, start enable, busy pin, power
    localparam [15:0] BASE = 16'h04E0;

    adcc_control u_dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .external_trigger_pin(trig[0]), .general_timer_one(trig[1]),
        .general_timer_zero(trig[2]), .programmable_logic_trigger(trig[3]),
        .converter_clock(conv_clk), .conv_power_en(pwr), .conv_input_mode(mode),
        .conv_sample_en(samp), .conv_start_pulse(startp), .conv_done_pulse(donep),
        .conversion_active_pin(act), .conversion_active_pin_oe_n(act_oe_n),
        .power_settled(settled));

    always #10 sys_clk = ~sys_clk;

    // length of the last acquisition in system clocks, counted edge by edge
    always @(posedge sys_clk)
    begin
        if (samp === 1'b1)
            acq_run <= acq_run + 1;
        else
            acq_run <= 0;
        if (samp !== 1'b1 && acq_run != 0)
            acq_len <= acq_run;
    end

    task tick(input int c);
        repeat (c) @(posedge sys_clk);
    endtask

    task wr(input [3:0] a, input [15:0] d);
    begin
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    end
    endtask

    task rd(input [3:0] a, input [15:0] e);
    begin
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 `CHK("read data", e, reg_rdata)
    end
    endtask

    task pulse(input int k);
    begin
        @(posedge sys_clk);
        trig[k] <= 1'b1;
        tick(2);
        trig[k] <= 1'b0;
    end
    endtask

    task quiet(input int c);
    begin
        m = 0;
        repeat (c) begin @(posedge sys_clk); #1 if (samp === 1'b1) m++; end
        `CHK("no launch", 0, m)
    end
    endtask

    task wait_done;
    begin
        n = 0;
        while (donep !== 1'b1 && n < 100) begin @(posedge sys_clk); #1 n++; end
        `CHK("done pulse", 1'b1, donep)
    end
    endtask

    // one conversion: launch, acquisition length in cycles, busy pin, result
    task conv(input int a, input bit b);
    begin
        n = 0;
        while (samp !== 1'b1 && n < 40) begin @(posedge sys_clk); #1 n++; end
        `CHK("launch", 1'b1, samp)
        `CHK("busy pin", b, act)
        while (samp === 1'b1) @(posedge sys_clk);
        @(posedge sys_clk);
        #1 `CHK("acquisition", 1'b1, acq_len >= 2 * a - 1 && acq_len <= 2 * a)
        wait_done();
    end
    endtask

    task conclude;
    begin
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask

    // bound on the whole run, far above the few thousand cycles it needs
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            fail_count++;
            conclude();
        end
    end

    initial
    begin
        tick(12);
        srst <= 1'b0;
        rd(`ADCC_CTRL_ADDR, `ADCC_CTRL_RESET);
        rd(`ADCC_STAT_ADDR, 16'h0000);
        rd(4'h8, 16'h0000);
        wr(`ADCC_CTRL_ADDR, 16'h0010);
        wr(`ADCC_CTRL_ADDR, 16'hE018);
        rd(`ADCC_CTRL_ADDR, 16'h0010);
        $display("test registers done");
        wr(`ADCC_CTRL_ADDR, BASE);
        tick(3);
        `CHK("power", 1'b1, pwr)
        `CHK("pin enable", 1'b0, act_oe_n)
        tick(200);
        `CHK("settled early", 1'b0, settled)
        tick(60);
        rd(`ADCC_STAT_ADDR, 16'h0002);
        for (i = 0; i < 3; i++)
        begin
            wr(`ADCC_CTRL_ADDR, 16'(BASE | (i << 3)));
            tick(3);
            `CHK("input mode", i[1:0], mode)
        end
        $display("test power and modes done");
        for (i = 0; i < 4; i++)
        begin
            wr(`ADCC_CTRL_ADDR, 16'((BASE | (i << 8) | tt[i]) & 16'hFF7F));
            pulse(i);
            quiet(30);
            wr(`ADCC_CTRL_ADDR, 16'(BASE | (i << 8) | tt[i]));
            pulse((i + 1) % 4);
            quiet(30);
            pulse(i);
            conv(2 << i, 1'b1);
        end
        $display("test trigger sources done");
        wr(`ADCC_CTRL_ADDR, BASE | 16'h0003);
        conv(2, 1'b1);
        tick(2);
        rd(`ADCC_CTRL_ADDR, BASE);
        quiet(40);
        wr(`ADCC_CTRL_ADDR, (BASE & 16'hFFBF) | 16'h0003);
        conv(2, 1'b0);
        `CHK("pin released", 1'b1, act_oe_n)
        wr(`ADCC_CTRL_ADDR, BASE & 16'hFF3F);
        pulse(0);
        quiet(30);
        $display("test single conversion done");
        wr(`ADCC_CTRL_ADDR, BASE | 16'h0004);
        conv(2, 1'b1);
        wr(`ADCC_CTRL_ADDR, (BASE & 16'hFF7F) | 16'h0004);
        rd(`ADCC_STAT_ADDR, 16'h0007);
        wait_done();
        conv(2, 1'b1);
        conv(2, 1'b1);
        wr(`ADCC_CTRL_ADDR, BASE & 16'hFF7F);
        tick(60);
        quiet(60);
        $display("test continuous done");
        for (i = 1; i < 6; i++)
        begin
            wr(`ADCC_CTRL_ADDR, 16'((i << 10) | 16'h0020));
            tick(80);
            m = 0;
            prv = conv_clk;
            repeat (128)
            begin
                @(posedge sys_clk);
                #1 if (conv_clk && !prv) m++;
                prv = conv_clk;
            end
            `CHK("divider", 128 >> i, m)
        end
        $display("test divider done");
        conclude();
    end
endmodule // testbench
